// [sim/fp_nan_propagation_unit_test.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the NaN unit
// ----------------------------------------
module fp_nan_propagation_unit_test;
   localparam logic [3:0] WR = 4'h8; // Write only
   localparam logic [3:0] WF = 4'hc; // Write and flag
   localparam logic [3:0] TR = 4'h6; // Flag and trap
   localparam fpnan_pkg::fpnan_op_t DY = fpnan_pkg::OP_DYADIC;
   localparam fpnan_pkg::fpnan_op_t MO = fpnan_pkg::OP_MONADIC;
   localparam fpnan_pkg::fpnan_insn_t GE = fpnan_pkg::INSN_GENERIC;
   localparam fpnan_pkg::fpnan_fmt_t SG = fpnan_pkg::FMT_SINGLE;
   logic clock = 1'b0; // Core clock
   logic rstn = 1'b0; // Reset, active low
   logic opValid, modeSimd, invalidMask, otherInvalid; // Issue controls
   fpnan_pkg::fpnan_op_t opKind; // Shape
   fpnan_pkg::fpnan_insn_t insnClass; // Family
   fpnan_pkg::fpnan_fmt_t fmt; // Format
   logic [79:0] srcA, srcB, plainRes, resData_q; // Data paths
   logic resValid_q, resWrite_q, invalidFlag_q, invalidTrap_q, formatError_q; // Status
   int n_errors = 0; // Mismatches
   int num_checks = 0; // Comparisons
   always #5 clock = ~clock;
   fpnan_issue_model pipe (.clock(clock), .opValid(opValid), .opKind(opKind),
      .insnClass(insnClass), .fmt(fmt), .modeSimd(modeSimd), .invalidMask(invalidMask),
      .otherInvalid(otherInvalid), .srcA(srcA), .srcB(srcB), .plainRes(plainRes));
   fpnan_unit dut (.clock(clock), .rstn(rstn), .opValid(opValid), .opKind(opKind),
      .insnClass(insnClass), .fmt(fmt), .modeSimd(modeSimd), .invalidMask(invalidMask),
      .otherInvalid(otherInvalid), .srcA(srcA), .srcB(srcB), .plainRes(plainRes),
      .resValid_q(resValid_q), .resWrite_q(resWrite_q), .resData_q(resData_q),
      .invalidFlag_q(invalidFlag_q), .invalidTrap_q(invalidTrap_q),
      .formatError_q(formatError_q));
   // ----------------------------------------
   // Shared issue and compare
   // ----------------------------------------
   task automatic run(input fpnan_pkg::fpnan_op_t k, input fpnan_pkg::fpnan_insn_t c,
      input fpnan_pkg::fpnan_fmt_t f, input logic s, input logic m, input logic o,
      input logic [79:0] a, input logic [79:0] b, input logic [3:0] fl, input logic [79:0] d);
      pipe.issue(k, c, f, s, m, o, a, b);
      num_checks++;
      if ({resValid_q, resWrite_q, invalidFlag_q, invalidTrap_q, formatError_q} !== {1'b1, fl})
      begin
         $display("mismatch flags exp %b got %b", {1'b1, fl},
            {resValid_q, resWrite_q, invalidFlag_q, invalidTrap_q, formatError_q});
         n_errors++;
      end
      if (fl[3] && resData_q !== d)
      begin
         $display("mismatch resData_q exp %h got %h", d, resData_q);
         n_errors++;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_trap();
      run(MO, GE, SG, 1'b0, 1'b0, 1'b0, 80'h7f80_0001, 80'h0, TR, 80'h0);
   endtask
   task automatic s_mixed();
      run(DY, GE, SG, 1'b0, 1'b1, 1'b0, 80'h7f80_0001, 80'h7fc0_0005, WF, 80'h7fc0_0005);
      run(DY, GE, SG, 1'b1, 1'b1, 1'b0, 80'h7f80_0001, 80'h7fc0_0005, WF, 80'h7fc0_0001);
      run(DY, GE, SG, 1'b1, 1'b1, 1'b0, 80'h7fc0_0005, 80'h7f80_0001, WF, 80'h7fc0_0005);
   endtask
   task automatic s_two_signal();
      run(DY, GE, SG, 1'b0, 1'b1, 1'b0, 80'h7f80_0001, 80'h7f80_0003, WF, 80'h7fc0_0003);
      run(DY, GE, SG, 1'b1, 1'b1, 1'b0, 80'h7f80_0001, 80'h7f80_0003, WF, 80'h7fc0_0001);
      run(DY, GE, fpnan_pkg::FMT_DOUBLE, 1'b0, 1'b1, 1'b0, 80'h7ff0_0000_0000_0005,
         80'h7ff0_0000_0000_0001, WF, 80'h7ff8_0000_0000_0005);
   endtask
   task automatic s_two_quiet();
      run(DY, GE, SG, 1'b0, 1'b1, 1'b0, 80'h7fc0_0001, 80'hffc0_0009, WR, 80'hffc0_0009);
      run(DY, GE, SG, 1'b1, 1'b1, 1'b0, 80'h7fc0_0001, 80'hffc0_0009, WR, 80'h7fc0_0001);
   endtask
   task automatic s_with_number();
      run(DY, GE, SG, 1'b1, 1'b1, 1'b0, 80'h3f80_0000, 80'h7f80_0002, WF, 80'h7fc0_0002);
      run(DY, GE, SG, 1'b0, 1'b1, 1'b0, 80'h7f80_0000, 80'h7fc0_0002, WR, 80'h7fc0_0002);
      run(DY, GE, SG, 1'b0, 1'b1, 1'b0, 80'h3f80_0000, 80'h3f80_0000, WR, 80'h4000_0000);
   endtask
   task automatic s_monadic();
      run(MO, GE, fpnan_pkg::FMT_EXTENDED, 1'b0, 1'b1, 1'b0, 80'h7fff_8000_0000_0000_0001,
         80'h0, WF, 80'h7fff_c000_0000_0000_0001);
      run(MO, GE, SG, 1'b0, 1'b1, 1'b0, 80'h7f80_0009, 80'h0, WF, 80'h7fc0_0009);
      run(MO, GE, SG, 1'b1, 1'b1, 1'b0, 80'hffc0_0007, 80'h0, WR, 80'hffc0_0007);
   endtask
   task automatic s_indefinite();
      run(MO, GE, SG, 1'b0, 1'b1, 1'b1, 80'h0, 80'h0, WF, fpnan_pkg::INDEF_SGL);
      run(DY, GE, fpnan_pkg::FMT_DOUBLE, 1'b1, 1'b1, 1'b1, 80'h0, 80'h0, WF,
         fpnan_pkg::INDEF_DBL);
      run(DY, GE, fpnan_pkg::FMT_EXTENDED, 1'b0, 1'b1, 1'b1, 80'h0, 80'h0, WF,
         fpnan_pkg::INDEF_EXT);
   endtask
   task automatic s_families();
      run(DY, fpnan_pkg::INSN_STORE_INT_TRUNC, SG, 1'b1, 1'b1, 1'b0, 80'h7f80_0001,
         80'h7f80_0003, WF, 80'h7fc0_0003);
      run(DY, fpnan_pkg::INSN_VECTOR, SG, 1'b0, 1'b1, 1'b0, 80'h7f80_0001,
         80'h7f80_0003, WF, 80'h7fc0_0001);
   endtask
   task automatic s_half();
      run(DY, GE, fpnan_pkg::FMT_HALF, 1'b0, 1'b1, 1'b0, 80'h3c00, 80'h3c00, 4'h1, 80'h0);
      run(fpnan_pkg::OP_HALF_TO_SINGLE, GE, SG, 1'b1, 1'b1, 1'b0, 80'h7c01, 80'h0, WF,
         80'h7fc0_2000);
      run(fpnan_pkg::OP_SINGLE_TO_HALF, GE, SG, 1'b1, 1'b1, 1'b0, 80'h3f80_0000, 80'h0, WR,
         80'h3c00);
   endtask
   // Mid-run reset clears every output, data included
   task automatic s_reset();
      @(posedge clock);
      #1;
      rstn = 1'b0;
      #1;
      num_checks++;
      if ({resValid_q, resWrite_q, invalidFlag_q, invalidTrap_q, formatError_q} !== 5'h0
         || resData_q !== fpnan_pkg::RES_RESET)
      begin
         $display("mismatch reset exp 0 got %b %h",
            {resValid_q, resWrite_q, invalidFlag_q, invalidTrap_q, formatError_q}, resData_q);
         n_errors++;
      end
      @(posedge clock);
      #1;
      rstn = 1'b1;
   endtask
   // ----------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------
   task automatic give_verdict();
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Cut a hang far beyond the expected run
   initial
   begin
      #20000;
      n_errors++;
      give_verdict();
   end
   // Reset for six cycles, then every scenario
   initial
   begin
      repeat (6) @(posedge clock);
      #1;
      rstn = 1'b1;
      s_trap();
      s_mixed();
      s_two_signal();
      s_two_quiet();
      s_with_number();
      s_monadic();
      s_indefinite();
      s_families();
      s_half();
      s_reset();
      s_trap();
      give_verdict();
   end
endmodule

// [sim/fpnan_issue_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Issuing pipeline model
// ----------------------------------------
module fpnan_issue_model (
   input wire logic clock, // Core clock
   output logic opValid, // Operation present
   output fpnan_pkg::fpnan_op_t opKind, // Operation shape
   output fpnan_pkg::fpnan_insn_t insnClass, // Instruction family
   output fpnan_pkg::fpnan_fmt_t fmt, // Format
   output logic modeSimd, // Mode select
   output logic invalidMask, // Invalid mask
   output logic otherInvalid, // Invalid without NaN
   output logic [79:0] srcA, // First source
   output logic [79:0] srcB, // Second source
   output logic [79:0] plainRes // Ordinary result
);
   // Idle values at time zero
   initial
   begin
      {opValid, modeSimd, invalidMask, otherInvalid} = 4'h0;
      opKind = fpnan_pkg::OP_DYADIC;
      insnClass = fpnan_pkg::INSN_GENERIC;
      fmt = fpnan_pkg::FMT_SINGLE;
      {srcA, srcB, plainRes} = '0;
   end
   // One operation held for one edge, mode and mask always with it
   task automatic issue(input fpnan_pkg::fpnan_op_t k, input fpnan_pkg::fpnan_insn_t c,
      input fpnan_pkg::fpnan_fmt_t f, input logic s, input logic m, input logic o,
      input logic [79:0] a, input logic [79:0] b);
      @(posedge clock);
      #1;
      opValid = 1'b1;
      opKind = k;
      insnClass = c;
      fmt = f;
      {modeSimd, invalidMask, otherInvalid} = {s, m, o};
      {srcA, srcB, plainRes} = {a, b, 80'h4000_0000};
      @(posedge clock);
      #1;
      opValid = 1'b0;
      // Withdrawn operands no longer show the old value
      {srcA, srcB, plainRes} = {~a, ~b, 80'h0};
   endtask
endmodule

// [sim/fpnan_unit_props.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checker for the NaN unit
// ----------------------------------------
module fpnan_unit_props (
   input wire logic clock, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic opValid, // Operation present
   input wire fpnan_pkg::fpnan_op_t opKind, // Operation shape
   input wire fpnan_pkg::fpnan_fmt_t fmt, // Arithmetic format
   input wire logic invalidMask, // Invalid masked
   input wire logic otherInvalid, // Invalid without NaN
   input wire logic [79:0] srcA, // First source
   input wire logic resValid_q, // Finished
   input wire logic resWrite_q, // Written
   input wire logic [79:0] resData_q, // Result
   input wire logic invalidFlag_q, // Flag
   input wire logic invalidTrap_q, // Trap
   input wire logic formatError_q // Half refused
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Single-format class helpers
   function automatic logic nanS(input logic [79:0] v);
      return v[30:23] == 8'hff && v[22:0] != 23'h0;
   endfunction
   function automatic logic snanS(input logic [79:0] v);
      return nanS(v) && !v[22];
   endfunction
   // Shorthand for a single-format monadic request
   logic monoS;
   assign monoS = opValid && opKind == fpnan_pkg::OP_MONADIC && fmt == fpnan_pkg::FMT_SINGLE;
   a_answer_next: assert property (opValid |=> resValid_q) else $error("no answer");
   a_idle_quiet: assert property (!resValid_q |-> !(resWrite_q || invalidFlag_q
      || invalidTrap_q || formatError_q)) else $error("pulse without answer");
   a_trap_no_write: assert property (invalidTrap_q |-> !resWrite_q && invalidFlag_q)
      else $error("trap wrote result");
   a_trap_unmasked: assert property (monoS && !invalidMask && snanS(srcA)
      |=> invalidTrap_q) else $error("no trap");
   a_masked_quiet: assert property (monoS && invalidMask && snanS(srcA)
      |=> invalidFlag_q && resWrite_q && resData_q == ($past(srcA) | 80'h40_0000))
      else $error("bad quiet");
   a_quiet_kept: assert property (monoS && invalidMask && !otherInvalid
      && nanS(srcA) && srcA[22] |=> !invalidFlag_q && resWrite_q && resData_q == $past(srcA))
      else $error("quiet changed");
   a_indef_single: assert property (monoS && invalidMask && otherInvalid
      && !nanS(srcA) |=> resData_q == fpnan_pkg::INDEF_SGL) else $error("no indefinite");
   a_half_refused: assert property (opValid && fmt == fpnan_pkg::FMT_HALF
      && (opKind == fpnan_pkg::OP_DYADIC || opKind == fpnan_pkg::OP_MONADIC)
      |=> formatError_q && !resWrite_q && !invalidFlag_q) else $error("half computed");
   a_data_holds: assert property (!opValid |=> $stable(resData_q)) else $error("data moved");
   a_no_signal: assert property (resWrite_q && $past(fmt) == fpnan_pkg::FMT_SINGLE
      && $past(opKind) != fpnan_pkg::OP_SINGLE_TO_HALF |-> !snanS(resData_q))
      else $error("signaling result");
endmodule
bind fpnan_unit fpnan_unit_props u_props (.clock(clock), .rstn(rstn), .opValid(opValid),
   .opKind(opKind), .fmt(fmt), .invalidMask(invalidMask), .otherInvalid(otherInvalid),
   .srcA(srcA), .resValid_q(resValid_q), .resWrite_q(resWrite_q), .resData_q(resData_q),
   .invalidFlag_q(invalidFlag_q), .invalidTrap_q(invalidTrap_q),
   .formatError_q(formatError_q));

// [verilog/fpnan_class_if.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Classification of one operand
// ----------------------------------------
interface fpnan_class_if;
   logic isNan;                              // Any NaN
   logic isQuiet;                            // Quiet NaN
   logic isSignal;                           // Signaling NaN
   logic [fpnan_pkg::FRAC_W-1:0] frac;       // Fraction, right aligned
   modport producer (output isNan, output isQuiet, output isSignal, output frac);
   modport consumer (input isNan, input isQuiet, input isSignal, input frac);
endinterface

// [verilog/fpnan_classify.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Operand classifier
// ----------------------------------------
module fpnan_classify (
   input wire logic [fpnan_pkg::FP_W-1:0] value, // Operand bits
   input wire fpnan_pkg::fpnan_fmt_t fmt,        // Operand format
   fpnan_class_if.producer cls                   // Classification result
);
   logic expMax; // Exponent at its maximum

   // Exponent and fraction extraction, sign ignored
   always_comb
   begin
      case (fmt)
         fpnan_pkg::FMT_HALF:
         begin
            expMax = &value[fpnan_pkg::HALF_EXP_LSB +: 5];
            cls.frac = {54'h0, value[9:0]};
         end
         fpnan_pkg::FMT_DOUBLE:
         begin
            expMax = &value[fpnan_pkg::DBL_EXP_LSB +: 11];
            cls.frac = {12'h0, value[51:0]};
         end
         fpnan_pkg::FMT_EXTENDED:
         begin
            // Explicit integer bit excluded from the fraction
            expMax = &value[fpnan_pkg::EXT_EXP_LSB +: 15];
            cls.frac = {1'b0, value[62:0]};
         end
         default:
         begin
            expMax = &value[fpnan_pkg::SGL_EXP_LSB +: 8];
            cls.frac = {41'h0, value[22:0]};
         end
      endcase
      cls.isNan = expMax && (cls.frac != 64'h0);
      cls.isQuiet = cls.isNan && value[fpnan_pkg::qbitOf(fmt)];
      cls.isSignal = cls.isNan && !value[fpnan_pkg::qbitOf(fmt)];
   end
endmodule

// [verilog/fpnan_convert.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Half and single conversion
// ----------------------------------------
module fpnan_convert (
   input wire logic toSingle,       // 1: half to single, 0: single to half
   input wire logic [31:0] value,   // Source in low bits
   output logic [31:0] result       // Converted value, NaNs quieted
);
   logic [4:0] pos;       // Leading one of a subnormal half
   logic [9:0] normFrac;  // Normalised subnormal fraction

   // Leading one search for subnormal halves
   always_comb
   begin
      pos = 5'h0;
      for (int i = 0; i < 10; i++)
      begin
         if (value[i])
         begin
            pos = 5'(i);
         end
      end
      normFrac = 10'(value[9:0] << (5'd10 - pos));
   end

   // Conversion proper
   always_comb
   begin
      if (toSingle)
      begin
         if (value[14:10] == 5'h1f)
         begin
            // Infinity, or NaN with payload kept and quiet bit forced
            result = (value[9:0] == 10'h0) ? {value[15], 8'hff, 23'h0} :
               {value[15], 8'hff, 1'b1, value[8:0], 13'h0};
         end
         else if (value[14:10] == 5'h0)
         begin
            // Zero, or subnormal renormalised
            result = (value[9:0] == 10'h0) ? {value[15], 31'h0} :
               {value[15], 8'(pos + 5'd0) + 8'd103, normFrac, 13'h0};
         end
         else
         begin
            result = {value[15], 8'(value[14:10]) + 8'd112, value[9:0], 13'h0};
         end
      end
      else
      begin
         if (value[30:23] == 8'hff)
         begin
            result = (value[22:0] == 23'h0) ? {16'h0, value[31], 5'h1f, 10'h0} :
               {16'h0, value[31], 5'h1f, 1'b1, value[21:13]};
         end
         else if (value[30:23] > 8'd142)
         begin
            // Toward zero: largest finite half
            result = {16'h0, value[31], 5'h1e, 10'h3ff};
         end
         else if (value[30:23] < 8'd113)
         begin
            // Below normal half range: signed zero
            result = {16'h0, value[31], 15'h0};
         end
         else
         begin
            result = {16'h0, value[31], 5'(value[30:23] - 8'd112), value[22:13]};
         end
      end
   end
endmodule

// [verilog/fpnan_pkg.sv]
package fpnan_pkg;

   // ----------------------------------------
   // Widths and encodings
   // ----------------------------------------
   localparam int unsigned FP_W = 80;   // Widest operand, extended format
   localparam int unsigned FRAC_W = 64; // Common fraction carrier width

   typedef enum logic [1:0] {
      FMT_SINGLE = 2'h0,
      FMT_DOUBLE = 2'h1,
      FMT_EXTENDED = 2'h2,
      FMT_HALF = 2'h3
   } fpnan_fmt_t;

   typedef enum logic [1:0] {
      OP_DYADIC = 2'h0,        // Two-operand arithmetic
      OP_MONADIC = 2'h1,       // One-operand arithmetic
      OP_HALF_TO_SINGLE = 2'h2, // half_to_single_convert
      OP_SINGLE_TO_HALF = 2'h3  // single_to_half_convert
   } fpnan_op_t;

   typedef enum logic [1:0] {
      INSN_GENERIC = 2'h0,     // Mode taken from the mode input
      INSN_STORE_INT_TRUNC = 2'h1, // store_integer_truncate_pop
      INSN_VECTOR = 2'h2       // Advanced vector instructions
   } fpnan_insn_t;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned HALF_QBIT = 9;
   localparam int unsigned SGL_QBIT = 22;
   localparam int unsigned DBL_QBIT = 51;
   localparam int unsigned EXT_QBIT = 62;
   localparam int unsigned HALF_EXP_LSB = 10;
   localparam int unsigned SGL_EXP_LSB = 23;
   localparam int unsigned DBL_EXP_LSB = 52;
   localparam int unsigned EXT_EXP_LSB = 64;

   // ----------------------------------------
   // Indefinite encodings and reset values
   // ----------------------------------------
   localparam logic [FP_W-1:0] INDEF_HALF = 80'h0000_0000_0000_0000_fe00;
   localparam logic [FP_W-1:0] INDEF_SGL = 80'h0000_0000_0000_ffc0_0000;
   localparam logic [FP_W-1:0] INDEF_DBL = 80'h0000_fff8_0000_0000_0000;
   localparam logic [FP_W-1:0] INDEF_EXT = 80'hffff_c000_0000_0000_0000;
   localparam logic [FP_W-1:0] RES_RESET = 80'h0;

   // Position of the quiet bit for a format
   function automatic int unsigned qbitOf(input fpnan_fmt_t fmt);
      case (fmt)
         FMT_HALF: qbitOf = HALF_QBIT;
         FMT_DOUBLE: qbitOf = DBL_QBIT;
         FMT_EXTENDED: qbitOf = EXT_QBIT;
         default: qbitOf = SGL_QBIT;
      endcase
   endfunction

   // Force the quiet bit, all other bits kept
   function automatic logic [FP_W-1:0] quietOf(input logic [FP_W-1:0] v, input fpnan_fmt_t fmt);
      logic [FP_W-1:0] q;
      q = v;
      q[qbitOf(fmt)] = 1'b1;
      quietOf = q;
   endfunction

   // Reserved indefinite value of a format
   function automatic logic [FP_W-1:0] indefOf(input fpnan_fmt_t fmt);
      case (fmt)
         FMT_HALF: indefOf = INDEF_HALF;
         FMT_DOUBLE: indefOf = INDEF_DBL;
         FMT_EXTENDED: indefOf = INDEF_EXT;
         default: indefOf = INDEF_SGL;
      endcase
   endfunction

endpackage

// [verilog/fpnan_unit.sv]
`timescale 1ns/1ps
// ----------------------------------------
// NaN propagation and result selection
// ----------------------------------------
module fpnan_unit (
   input wire logic clock,                          // Core clock, 100 MHz
   input wire logic rstn,                           // Async reset, active low
   input wire logic opValid,                        // Operation present
   input wire fpnan_pkg::fpnan_op_t opKind,         // Operation shape
   input wire fpnan_pkg::fpnan_insn_t insnClass,    // Instruction family
   input wire fpnan_pkg::fpnan_fmt_t fmt,           // Arithmetic format
   input wire logic modeSimd,                       // 1: SIMD, 0: legacy stack
   input wire logic invalidMask,                    // Invalid exception masked
   input wire logic otherInvalid,                   // Invalid raised without NaN
   input wire logic [fpnan_pkg::FP_W-1:0] srcA,     // First source
   input wire logic [fpnan_pkg::FP_W-1:0] srcB,     // Second source
   input wire logic [fpnan_pkg::FP_W-1:0] plainRes, // Ordinary computed result
   output logic resValid_q,                         // Operation finished
   output logic resWrite_q,                         // Destination written
   output logic [fpnan_pkg::FP_W-1:0] resData_q,    // Result value
   output logic invalidFlag_q,                      // Invalid flag raised
   output logic invalidTrap_q,                      // Unmasked invalid trap
   output logic formatError_q                       // Half arithmetic refused
);
   // ----------------------------------------
   // Classification
   // ----------------------------------------
   fpnan_class_if clsA ();                // First operand class
   fpnan_class_if clsB ();                // Second operand class
   fpnan_pkg::fpnan_fmt_t inFmt;          // Format the sources are in
   fpnan_pkg::fpnan_fmt_t outFmt;         // Format of the result
   logic isConv;                          // Conversion operation
   logic [31:0] convRes;                  // Conversion output

   // Source and result formats per operation
   always_comb
   begin
      case (opKind)
         fpnan_pkg::OP_HALF_TO_SINGLE:
         begin
            inFmt = fpnan_pkg::FMT_HALF;
            outFmt = fpnan_pkg::FMT_SINGLE;
         end
         fpnan_pkg::OP_SINGLE_TO_HALF:
         begin
            inFmt = fpnan_pkg::FMT_SINGLE;
            outFmt = fpnan_pkg::FMT_HALF;
         end
         default:
         begin
            inFmt = fmt;
            outFmt = fmt;
         end
      endcase
   end

   assign isConv = (opKind == fpnan_pkg::OP_HALF_TO_SINGLE) ||
      (opKind == fpnan_pkg::OP_SINGLE_TO_HALF);

   fpnan_classify uClsA (
      .value (srcA),
      .fmt (inFmt),
      .cls (clsA)
   );

   fpnan_classify uClsB (
      .value (srcB),
      .fmt (inFmt),
      .cls (clsB)
   );

   // Half values only pass through the converter
   fpnan_convert uConv (
      .toSingle (opKind == fpnan_pkg::OP_HALF_TO_SINGLE),
      .value (srcA[31:0]),
      .result (convRes)
   );

   // ----------------------------------------
   // Selection
   // ----------------------------------------
   logic legacy;        // Legacy stack selection in force
   logic dyadic;        // Second operand takes part
   logic bNan;          // Second operand is a NaN that counts
   logic bSig;          // Second operand signaling and counts
   logic anyNan;        // Some operand is a NaN
   logic anySig;        // Some operand is signaling
   logic halfArith;     // Arithmetic asked on half values
   logic [fpnan_pkg::FP_W-1:0] larger; // Operand with larger significand
   logic [fpnan_pkg::FP_W-1:0] nanRes; // NaN chosen for the result

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   // Store-truncate and vector families override the mode input
   always_comb
   begin
      case (insnClass)
         fpnan_pkg::INSN_STORE_INT_TRUNC: legacy = 1'b1;
         fpnan_pkg::INSN_VECTOR: legacy = 1'b0;
         default: legacy = !modeSimd;
      endcase
   end

   assign dyadic = (opKind == fpnan_pkg::OP_DYADIC);
   assign bNan = dyadic && clsB.isNan;
   assign bSig = dyadic && clsB.isSignal;
   assign anyNan = clsA.isNan || bNan;
   assign anySig = clsA.isSignal || bSig;
   assign halfArith = !isConv && (fmt == fpnan_pkg::FMT_HALF);
   // Tie on significands keeps the first source
   assign larger = (clsB.frac > clsA.frac) ? srcB : srcA;

   // ----------------------------------------
   // NaN result
   // ----------------------------------------
   // A quiet NaN comes back from quietOf unchanged, so one path
   // serves both the signaling and the quiet single-NaN cases.
   // NaN result table
   always_comb
   begin
      if (isConv)
      begin
         nanRes = {48'h0, convRes}; // Converter already quiets
      end
      else if (clsA.isNan && bNan)
      begin
         if (clsA.isSignal && clsB.isSignal)
         begin
            // Both signaling
            nanRes = legacy ? fpnan_pkg::quietOf(larger, fmt) :
               fpnan_pkg::quietOf(srcA, fmt);
         end
         else if (clsA.isQuiet && clsB.isQuiet)
         begin
            nanRes = legacy ? larger : srcA;
         end
         else
         begin
            // One of each
            nanRes = legacy ? (clsA.isQuiet ? srcA : srcB) :
               fpnan_pkg::quietOf(srcA, fmt);
         end
      end
      else if (clsA.isNan)
      begin
         // Single NaN operand, quiet bit forced either way
         nanRes = fpnan_pkg::quietOf(srcA, fmt);
      end
      else
      begin
         nanRes = fpnan_pkg::quietOf(srcB, fmt);
      end
   end

   // ----------------------------------------
   // Outcome
   // ----------------------------------------
   logic invalid;       // Invalid operation detected
   logic doWrite;       // Destination is written
   logic [fpnan_pkg::FP_W-1:0] outVal; // Value written

   // ----------------------------------------
   // Invalid operation
   // ----------------------------------------
   // Invalid causes; refused half arithmetic raises none
   always_comb
   begin
      if (halfArith)
      begin
         invalid = 1'b0; // Refused before any
      end
      else if (anySig)
      begin
         invalid = 1'b1; // Signaling operand
      end
      else
      begin
         invalid = otherInvalid; // Raised without a NaN
      end
   end

   // ----------------------------------------
   // Write decision
   // ----------------------------------------
   // Priority, highest first: refused half arithmetic, unmasked
   // trap, NaN result, masked indefinite, ordinary result. The trap
   // sits above the NaN path so that a trapped operation never
   // reaches the destination.
   // Write decision and written value
   always_comb
   begin
      outVal = fpnan_pkg::RES_RESET;
      doWrite = 1'b0;
      if (halfArith)
      begin
         doWrite = 1'b0; // Refused outright
      end
      else if (invalid && !invalidMask)
      begin
         doWrite = 1'b0; // Trap, destination untouched
      end
      else if (anyNan)
      begin
         doWrite = 1'b1;
         outVal = nanRes;
      end
      else if (invalid)
      begin
         doWrite = 1'b1;
         outVal = fpnan_pkg::indefOf(outFmt);
      end
      else
      begin
         doWrite = 1'b1;
         outVal = isConv ? {48'h0, convRes} : plainRes;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Completion strobe
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         resValid_q <= 1'b0;
      end
      else
      begin
         resValid_q <= opValid;
      end
   end

   // Destination write strobe
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         resWrite_q <= 1'b0; // No write in reset
      end
      else
      begin
         resWrite_q <= opValid && doWrite;
      end
   end

   // Result data, held until the next taken operation
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         resData_q <= fpnan_pkg::RES_RESET; // Known value after reset
      end
      else if (opValid)
      begin
         resData_q <= outVal; // Loaded even when the write is refused
      end
   end

   // ----------------------------------------
   // Exception indications
   // ----------------------------------------
   // Invalid flag, masked or unmasked
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         invalidFlag_q <= 1'b0; // Clear in reset
      end
      else
      begin
         invalidFlag_q <= opValid && invalid;
      end
   end

   // Trap request, only while the exception is unmasked
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         invalidTrap_q <= 1'b0; // Clear in reset
      end
      else
      begin
         invalidTrap_q <= opValid && invalid && !invalidMask;
      end
   end

   // Refusal of arithmetic on half values
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         formatError_q <= 1'b0; // Clear in reset
      end
      else
      begin
         formatError_q <= opValid && halfArith;
      end
   end
endmodule
